/* test/cpwm_load.sv */
/*
 * Load model on the PWM pin: counts high pin cycles inside a window.
 * Assumes the pin is a register output sampled on pclk.
 */
`timescale 1ns/1ns
`default_nettype none
module cpwm_load (
    input  wire logic        pclk,
    input  wire logic        clr,
    input  wire logic        win,
    input  wire logic        pin,
    output logic      [15:0] high_cnt
);
    // ************************************************
    // High time counter
    // ************************************************
    // Passive load: it never drives back, so it cannot mask a pin fault
    always_ff @(posedge pclk)
    begin
        if (clr)
            high_cnt <= 16'h0000;
        else if (win && pin)
            high_cnt <= high_cnt + 16'h0001;
    end
endmodule : cpwm_load
`default_nettype wire

/* test/tb_top.sv */
/*
 * Self-checking bench for the compare PWM channel behind APB.
 * Assumes the design files and the load model cpwm_load are compiled first.
 */
`timescale 1ns/1ns
`default_nettype none
`include "cpwm_consts.svh"
module tb_top;
    localparam logic [11:0] A_CTL1 = {7'h00, `CPWM_OFF_CTL1, 2'h0};
    localparam logic [11:0] A_PRI  = {7'h00, `CPWM_OFF_PRI, 2'h0};
    localparam logic [11:0] A_SEC  = {7'h00, `CPWM_OFF_SEC, 2'h0};
    localparam logic [11:0] A_PER  = {7'h00, `CPWM_OFF_PER, 2'h0};
    localparam logic [11:0] A_CTL2 = {7'h00, `CPWM_OFF_CTL2, 2'h0};
    localparam logic [11:0] A_STAT = {7'h00, `CPWM_OFF_STAT, 2'h0};
    localparam logic [31:0] SELF   = {27'h0, `CPWM_SYNC_SELF};
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [4:0]  tmr_tick = 5'h00;
    logic        cpu_idle = 1'b0;
    logic        fpa = 1'b0;
    logic        fpb = 1'b0;
    logic [2:0]  cmp = 3'h0;
    logic        pin;
    logic        fault_active;
    logic        clr = 1'b0;
    logic        win = 1'b0;
    logic [15:0] high_cnt;
    logic [31:0] r;
    logic [31:0] c1;
    logic        e;
    logic [15:0] per;
    logic [15:0] pri;
    logic [15:0] sec;
    logic [15:0] c0;
    logic [2:0]  m;
    int          i;
    int          n;
    int          err_count = 0;
    int          n_tests = 0;
    integer      seed = 32'h69A47E2E;

    cpwm_channel #(.CHANNEL_INDEX(1)) dut (
        .pclk              (pclk),
        .presetn           (presetn),
        .psel              (psel),
        .penable           (penable),
        .pwrite            (pwrite),
        .paddr             (paddr),
        .pwdata            (pwdata),
        .prdata            (prdata),
        .pready            (pready),
        .pslverr           (pslverr),
        .tmr_tick          (tmr_tick),
        .sync_in           (1'b0),
        .cpu_idle          (cpu_idle),
        .fault_pin_a       (fpa),
        .fault_pin_b       (fpb),
        .comparator_out    (cmp),
        .compare_output_pin(pin),
        .fault_active      (fault_active)
    );
    cpwm_load load (.pclk(pclk), .clr(clr), .win(win), .pin(pin), .high_cnt(high_cnt));

    always #5 pclk = ~pclk;

    // ************************************************
    // Checking and bus tasks
    // ************************************************
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 16; k++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k == 16)
        begin
            err_count++;
            report_and_stop();
        end
    endtask : apb

    task automatic rst(input int n_cyc);
        presetn <= 1'b0;
        repeat (n_cyc) @(posedge pclk);
        presetn <= 1'b1;
    endtask : rst

    function automatic logic [31:0] ctl1(logic idle, logic [2:0] tb, logic [2:0] en,
                                         logic [2:0] fl, logic [2:0] md);
        return {18'h0, idle, tb, en, fl, 1'b0, md};
    endfunction : ctl1

    function automatic logic [15:0] exp_high(logic [2:0] md, logic [15:0] p, logic [15:0] s,
                                             logic [15:0] pr);
        if (s > pr)
            return pr + 16'h0001;
        if (md == `CPWM_MODE_EDGE)
            return p;
        return (s > p) ? s - p : 16'h0000;
    endfunction : exp_high

    // Duty values first, mode last, so the first period is already right
    task automatic cfg(input logic [15:0] p, input logic [15:0] s, input logic [15:0] pr,
                       input logic [31:0] c2, input logic [31:0] cc);
        apb(1'b1, A_PRI, {16'h0, p});
        apb(1'b1, A_SEC, {16'h0, s});
        apb(1'b1, A_PER, {16'h0, pr});
        apb(1'b1, A_CTL2, c2);
        apb(1'b1, A_CTL1, cc);
    endtask : cfg

    task automatic measure(input int n_cyc, input logic [15:0] exp);
        @(posedge pclk);
        clr <= 1'b1;
        @(posedge pclk);
        clr <= 1'b0;
        win <= 1'b1;
        repeat (n_cyc) @(posedge pclk);
        win <= 1'b0;
        @(posedge pclk);
        chk({16'h0, high_cnt}, {16'h0, exp});
    endtask : measure

    task automatic fset(input int idx, input logic v);
        case (idx)
            0: fpa <= v;
            1: fpb <= v;
            2: cmp[0] <= v;
            default: cmp[1] <= v;
        endcase
    endtask : fset

    initial
    begin
        repeat (100000) @(posedge pclk);
        err_count++;
        report_and_stop();
    end

    // ************************************************
    // Main sequence
    // ************************************************
    initial
    begin
        rst(10);
        apb(1'b0, A_CTL1, 32'h0);
        chk(r, 32'h0);
        apb(1'b0, A_CTL2, 32'h0);
        chk(r, {27'h0, `CPWM_SYNC_RST});
        apb(1'b1, 12'h018, 32'hFFFF);
        chk({31'h0, e}, 32'h1);
        apb(1'b0, 12'h100, 32'h0);
        chk({e, r[30:0]}, 32'h80000000);
        apb(1'b0, A_CTL1, 32'h0);
        chk(r, 32'h0);
        $display("register test done");
        for (i = 0; i < 8; i++)
        begin
            rst(2);
            r = $random(seed);
            m = i[0] ? `CPWM_MODE_CENTER : `CPWM_MODE_EDGE;
            per = (i < 2) ? 16'h0000 : {12'h000, r[3:0]} + 16'h0001;
            pri = {8'h00, r[11:4]} % (per + 16'h0002);
            sec = r[20] ? per + {14'h0, r[22:21]} + 16'h0001 : 16'h0000;
            if (m == `CPWM_MODE_CENTER && !r[20])
            begin
                pri = {8'h00, r[11:4]} % (per + 16'h0001);
                sec = pri + {8'h00, r[19:12]} % (per + 16'h0001 - pri);
            end
            if (i < 2)
            begin
                pri = 16'h0000;
                sec = 16'h0000;
            end
            cpu_idle <= r[24];
            cfg(pri, sec, per, SELF, ctl1(1'b0, `CPWM_TB_PCLK, 3'h0, 3'h0, m));
            repeat (2 * per + 4) @(posedge pclk);
            c0 = 16'(3 * exp_high(m, pri, sec, per));
            measure(3 * (per + 1), c0);
            $display("pwm run %0d done", i);
        end
        rst(2);
        cpu_idle <= 1'b1;
        cfg(16'h0, 16'h0, 16'h9, SELF, ctl1(1'b1, `CPWM_TB_PCLK, 3'h0, 3'h0, `CPWM_MODE_EDGE));
        apb(1'b1, A_PRI, 32'hA);
        measure(30, 16'h0);
        cpu_idle <= 1'b0;
        repeat (12) @(posedge pclk);
        measure(30, 16'h001E);
        $display("buffer test done");
        for (i = 0; i < 7; i++)
        begin
            rst(2);
            cfg(16'h0, 16'h0, 16'hFFFF, SELF, ctl1(1'b0, i[2:0], 3'h0, 3'h0, `CPWM_MODE_EDGE));
            apb(1'b0, A_STAT, 32'h0);
            c0 = r[15:0];
            n = 0;
            repeat (20)
            begin
                @(posedge pclk);
                r = $random(seed);
                tmr_tick <= r[4:0];
                if (i < 5)
                    n += r[(i == 4) ? 0 : i + 1];
            end
            @(posedge pclk);
            tmr_tick <= 5'h00;
            apb(1'b0, A_STAT, 32'h0);
            chk({16'h0, r[15:0] - c0}, n);
        end
        $display("time base test done");
        // Fault pins in use: the compare interrupt enable lives outside the channel
        for (i = 0; i < 3; i++)
        begin
            rst(2);
            c1 = ctl1(1'b0, `CPWM_TB_PCLK, 3'h7, 3'h0, `CPWM_MODE_EDGE);
            cfg(i[0] ? 16'h0 : 16'h8, 16'h0, 16'h7, SELF | {17'h0, i[0], 14'h0}, c1);
            fset(i, 1'b1);
            repeat (6) @(posedge pclk);
            chk({31'h0, fault_active}, 32'h1);
            measure(16, i[0] ? 16'h0010 : 16'h0);
            apb(1'b0, A_CTL1, 32'h0);
            chk(r, c1 | (32'h10 << i));
            fset(i, 1'b0);
            repeat (20) @(posedge pclk);
            chk({31'h0, fault_active}, 32'h0);
            measure(16, i[0] ? 16'h0 : 16'h0010);
        end
        rst(2);
        cfg(16'h0, 16'h0, 16'h7, SELF | 32'hC000, c1);
        fset(1, 1'b1);
        repeat (6) @(posedge pclk);
        fset(1, 1'b0);
        repeat (24) @(posedge pclk);
        chk({31'h0, fault_active}, 32'h1);
        apb(1'b1, A_CTL1, c1);
        repeat (20) @(posedge pclk);
        chk({31'h0, fault_active}, 32'h0);
        fset(3, 1'b1);
        repeat (6) @(posedge pclk);
        chk({31'h0, fault_active}, 32'h0);
        fset(3, 1'b0);
        apb(1'b1, A_CTL1, ctl1(1'b0, `CPWM_TB_PCLK, 3'h7, 3'h0, 3'h3));
        fset(0, 1'b1);
        repeat (6) @(posedge pclk);
        chk({31'h0, fault_active}, 32'h0);
        apb(1'b0, A_CTL1, 32'h0);
        chk(r, ctl1(1'b0, `CPWM_TB_PCLK, 3'h7, 3'h0, 3'h3));
        $display("fault test done");
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire

/* verilog/cpwm_channel.sv */
/*
 * One output compare channel in PWM mode with fault inputs, behind APB.
 * Assumes timer ticks, comparator levels of the chip and cpu_idle come in;
 * fault pins and comparator levels are asynchronous to pclk.
 */
// Operation
// [RULE1] Duty values sit in hidden shadow copies; every PWM update is double-buffered. The code buffers only the duty values; per_q is used directly.
// [RULE2] Edge- or center-aligned waveform, chosen by the three-bit mode field.
// [RULE3] Software loads duty and period compare values before selecting PWM mode.
// [RULE4] Software makes the channel its own sync source with trigger select clear.
// [RULE5] A period value N gives a period of N plus one counts.
// [RULE6] Compare values write anytime; shadows load only when count equals period. The code also loads them every cycle outside PWM mode.
// [RULE7] Both compare values and period zero keep the output low.
// [RULE8] Secondary value above the period keeps the output high.
// [RULE9] A selected timer clocks the counter through its prescaler tick.
// [RULE10] Idle-stop bit 13 set halts the channel while the CPU idles.
// [RULE11] Bits 12..10 pick the time base; 110 and 101 are reserved.
// [RULE12] Bits 9, 8, 7 enable comparator, pin b and pin a faults.
// [RULE13] Fault flags at bits 6, 5, 4 are set by hardware on a fault.
// [RULE14] Fault enables and flags act only in the two PWM modes.
// [RULE15] Comparator one serves channels 1-2, two 3-4, three 5-6.
// [RULE16] Software using fault pins enables the compare interrupt.
// [RULE17] Mode 111 center-aligned, 110 edge-aligned, 000 disabled.
// [RULE18] Fault ends at a new period after the source goes; hold bit waits flags.
// [RULE19] During a fault the output follows the fault-level bit.
// [RULE20] Self-synced counter returns to zero on period match, loading shadows.
// [RULE21] Reset clears all implemented control one bits.
`timescale 1ns/1ns
`default_nettype none
`include "cpwm_consts.svh"
module cpwm_channel
    import cpwm_pkg::*;
#(
    parameter int CHANNEL_INDEX = 1
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [4:0]  tmr_tick,
    input  wire logic        sync_in,
    input  wire logic        cpu_idle,
    input  wire logic        fault_pin_a,
    input  wire logic        fault_pin_b,
    input  wire logic [2:0]  comparator_out,
    output logic             compare_output_pin,
    output logic             fault_active
);
    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [15:0]  ctl_q;
    logic [2:0]   flag_q;
    logic [2:0]   flag_d;
    logic [15:0]  pri_q;
    logic [15:0]  sec_q;
    logic [15:0]  per_q;
    logic [4:0]   sync_sel_q;
    logic         trig_q;
    logic         fout_q;
    logic         hold_q;
    logic [15:0]  cnt_q;
    logic [15:0]  pri_s_q;
    logic [15:0]  sec_s_q;
    logic         armed_q;
    cpwm_fstate_t fst_q;

    logic [2:0]   mode;
    logic         pwm;
    logic         tick;
    logic         run;
    logic         per_match;
    logic         self_sync;
    logic         wr_acc;
    logic [2:0]   src_s;
    logic [2:0]   hit;
    logic         pwm_hi;
    logic [31:0]  rd_d;
    logic         map_ok;

    assign mode      = ctl_q[`CPWM_MODE_MSB:0];
    assign pwm       = (mode == `CPWM_MODE_EDGE) || (mode == `CPWM_MODE_CENTER); // [RULE17]
    assign self_sync = (sync_sel_q == `CPWM_SYNC_SELF) && !trig_q;               // [RULE4]
    assign wr_acc    = psel && penable && pready && pwrite;

    // ****************************************************************
    // Input synchronisers and time base
    // ****************************************************************
    // Channel n shares comparator (n-1)/2 with the other channel of its pair
    cpwm_sync2 #(.WIDTH(3)) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({comparator_out[(CHANNEL_INDEX-1)/2], fault_pin_b, fault_pin_a}), // [RULE15]
        .sync_out (src_s)
    );

    cpwm_tbsel u_tbsel (
        .tb_sel   (ctl_q[`CPWM_TB_MSB:`CPWM_TB_LSB]),
        .tmr_tick (tmr_tick),
        .tick     (tick)
    );

    assign run = tick && (mode != `CPWM_MODE_OFF)
                 && !(ctl_q[`CPWM_IDLE_BIT] && cpu_idle)                  // [RULE10]
                 && (!trig_q || armed_q);
    assign per_match = run && (cnt_q == per_q);

    // ****************************************************************
    // APB slave
    // ****************************************************************
    assign map_ok = (paddr[11:5] == 7'h00) && (paddr[4:2] <= `CPWM_OFF_STAT);

    always_comb
    begin
        rd_d = 32'h0000_0000;
        case (paddr[4:2])
            `CPWM_OFF_CTL1: rd_d[15:0] = {ctl_q[15:7], flag_q, ctl_q[3:0]};
            `CPWM_OFF_PRI:  rd_d[15:0] = pri_q;
            `CPWM_OFF_SEC:  rd_d[15:0] = sec_q;
            `CPWM_OFF_PER:  rd_d[15:0] = per_q;
            `CPWM_OFF_CTL2: rd_d[15:0] = {hold_q, fout_q, 6'h00, trig_q, 2'h0, sync_sel_q};
            `CPWM_OFF_STAT: rd_d[17:0] = {fault_active, compare_output_pin, cnt_q};
            default:        rd_d = 32'h0000_0000;
        endcase
    end

    // One wait-free access phase: answer is prepared during setup
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !map_ok;
            prdata  <= (psel && !penable && !pwrite && map_ok) ? rd_d : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctl_q      <= `CPWM_CTL1_RST;                                 // [RULE21]
            pri_q      <= 16'h0000;
            sec_q      <= 16'h0000;
            per_q      <= 16'h0000;
            sync_sel_q <= `CPWM_SYNC_RST;
            trig_q     <= 1'b0;
            fout_q     <= 1'b0;
            hold_q     <= 1'b0;
        end
        else if (wr_acc && map_ok)
        begin
            case (paddr[4:2])
                `CPWM_OFF_CTL1: ctl_q <= pwdata[15:0] & `CPWM_CTL1_WMASK;
                `CPWM_OFF_PRI:  pri_q <= pwdata[15:0];                    // [RULE6]
                `CPWM_OFF_SEC:  sec_q <= pwdata[15:0];                    // [RULE6]
                `CPWM_OFF_PER:  per_q <= pwdata[15:0];
                `CPWM_OFF_CTL2:
                begin
                    hold_q     <= pwdata[`CPWM_HOLD_BIT];
                    fout_q     <= pwdata[`CPWM_FOUT_BIT];
                    trig_q     <= pwdata[`CPWM_TRIG_BIT];
                    sync_sel_q <= pwdata[`CPWM_SYNC_MSB:0];
                end
                default: ctl_q <= ctl_q;
            endcase
        end
    end

    // ****************************************************************
    // Fault flags: hardware set wins over a software clear
    // ****************************************************************
    assign hit = pwm ? (ctl_q[`CPWM_EN_MSB:`CPWM_EN_LSB] & src_s) : 3'h0; // [RULE12] [RULE14]

    always_comb
    begin
        flag_d = flag_q;
        if (wr_acc && map_ok && (paddr[4:2] == `CPWM_OFF_CTL1))
        begin
            flag_d = pwdata[`CPWM_FLAG_MSB:`CPWM_FLAG_LSB];
        end
        flag_d = flag_d | hit;                                            // [RULE13]
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flag_q <= 3'h0;                                               // [RULE21]
        end
        else
        begin
            flag_q <= flag_d;
        end
    end

    // ****************************************************************
    // Counter, trigger arming and shadows
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            armed_q <= 1'b0;
        end
        else if ((mode == `CPWM_MODE_OFF) || !trig_q)
        begin
            armed_q <= 1'b0;
        end
        else if (sync_in && (sync_sel_q != `CPWM_SYNC_NONE))
        begin
            armed_q <= 1'b1;
        end
        else if (ctl_q[`CPWM_TCLR_BIT] && run && (cnt_q == sec_s_q))
        begin
            armed_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q <= 16'h0000;
        end
        else if ((mode == `CPWM_MODE_OFF) || (trig_q && !armed_q))
        begin
            cnt_q <= 16'h0000;
        end
        else if (!trig_q && sync_in && !self_sync && (sync_sel_q != `CPWM_SYNC_NONE))
        begin
            cnt_q <= 16'h0000;
        end
        else if (run)
        begin
            // Free-running wraps at all ones; self sync closes the period
            cnt_q <= (per_match && self_sync) ? 16'h0000 : cnt_q + 16'h0001; // [RULE5] [RULE20]
        end
    end

    // Outside PWM the shadows track so the first period uses fresh values
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pri_s_q <= 16'h0000;
            sec_s_q <= 16'h0000;
        end
        else if (!pwm || per_match)
        begin
            pri_s_q <= pri_q;                                             // [RULE1] [RULE6]
            sec_s_q <= sec_q;                                             // [RULE1] [RULE6]
        end
    end

    // ****************************************************************
    // Fault state
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fst_q <= CPWM_RUN;
        end
        else if (!pwm)
        begin
            fst_q <= CPWM_RUN;                                            // [RULE14]
        end
        else
        begin
            case (fst_q)
                CPWM_RUN:
                    if (hit != 3'h0)
                    begin
                        fst_q <= CPWM_FAULT;                              // [RULE12]
                    end
                CPWM_FAULT:
                    if ((hit == 3'h0) && per_match && (!hold_q || (flag_q == 3'h0)))
                    begin
                        fst_q <= CPWM_RUN;                                // [RULE18]
                    end
                default: fst_q <= CPWM_RUN;
            endcase
        end
    end

    // ****************************************************************
    // Output pin
    // ****************************************************************
    always_comb
    begin
        if (sec_s_q > per_q)
        begin
            pwm_hi = 1'b1;                                                // [RULE8]
        end
        else if (mode == `CPWM_MODE_CENTER)
        begin
            pwm_hi = (cnt_q >= pri_s_q) && (cnt_q < sec_s_q);             // [RULE2]
        end
        else
        begin
            pwm_hi = cnt_q < pri_s_q;                                     // [RULE2] [RULE7]
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            compare_output_pin <= 1'b0;
            fault_active       <= 1'b0;
        end
        else
        begin
            compare_output_pin <= !pwm ? 1'b0 : (fst_q == CPWM_FAULT) ? fout_q : pwm_hi; // [RULE19]
            fault_active       <= pwm && (fst_q == CPWM_FAULT);
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence setup_s;
        psel && !penable;
    endsequence
    sequence fault_seen_s;
        pwm && (fst_q == CPWM_RUN) && (hit != 3'h0);
    endsequence

    apb_answer_a: assert property (setup_s |=> pready)
        else $error("no answer in access phase");
    shadow_hold_a: assert property (pwm && !per_match |=> $stable(pri_s_q) && $stable(sec_s_q)) // [RULE6]
        else $error("shadow changed mid period");
    period_wrap_a: assert property (self_sync && pwm && per_match && !sync_in |=> cnt_q == 16'h0000) // [RULE20]
        else $error("counter did not restart");
    zero_duty_a: assert property (pwm && fst_q == CPWM_RUN && per_q == 16'h0000
                                  && pri_s_q == 16'h0000 && sec_s_q == 16'h0000
                                  |=> !compare_output_pin) // [RULE7]
        else $error("output high at zero duty");
    full_duty_a: assert property (pwm && fst_q == CPWM_RUN && sec_s_q > per_q |=> compare_output_pin) // [RULE8]
        else $error("output low at full duty");
    idle_halt_a: assert property (ctl_q[`CPWM_IDLE_BIT] && cpu_idle && mode != 3'h0
                                  && !sync_in |=> $stable(cnt_q)) // [RULE10]
        else $error("counter ran in idle");
    tb_reserved_a: assert property ((ctl_q[12:10] == 3'h5 || ctl_q[12:10] == 3'h6) |-> !tick) // [RULE11]
        else $error("reserved time base ticked");
    fault_enter_a: assert property (fault_seen_s |=> fst_q == CPWM_FAULT ##1 fault_active) // [RULE12]
        else $error("fault not entered");
    flag_set_a: assert property (pwm && ctl_q[8] && src_s[1] |=> flag_q[1]) // [RULE13]
        else $error("pin b flag not set");
    flag_quiet_a: assert property (!pwm && !wr_acc |=> $stable(flag_q)) // [RULE14]
        else $error("flag moved outside PWM");
    fault_level_a: assert property (pwm && fst_q == CPWM_FAULT |=> compare_output_pin == $past(fout_q)) // [RULE19]
        else $error("wrong fault level");
endmodule : cpwm_channel
`default_nettype wire

/* verilog/cpwm_consts.svh */
/*
 * Offsets, field positions, codes and reset values of the compare PWM channel.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef CPWM_CONSTS_SVH
`define CPWM_CONSTS_SVH

// ****************************************************************
// Register word indices (byte address is four times)
// ****************************************************************
`define CPWM_OFF_CTL1      3'h0
`define CPWM_OFF_PRI       3'h1
`define CPWM_OFF_SEC       3'h2
`define CPWM_OFF_PER       3'h3
`define CPWM_OFF_CTL2      3'h4
`define CPWM_OFF_STAT      3'h5

// ****************************************************************
// Control one fields
// ****************************************************************
`define CPWM_IDLE_BIT      13
`define CPWM_TB_MSB        12
`define CPWM_TB_LSB        10
`define CPWM_EN_MSB        9
`define CPWM_EN_LSB        7
`define CPWM_FLAG_MSB      6
`define CPWM_FLAG_LSB      4
`define CPWM_TCLR_BIT      3
`define CPWM_MODE_MSB      2
`define CPWM_CTL1_WMASK    16'h3F8F
`define CPWM_CTL1_RST      16'h0000

// ****************************************************************
// Control two fields
// ****************************************************************
`define CPWM_HOLD_BIT      15
`define CPWM_FOUT_BIT      14
`define CPWM_TRIG_BIT      7
`define CPWM_SYNC_MSB      4
`define CPWM_SYNC_RST      5'h0C

// ****************************************************************
// Codes
// ****************************************************************
`define CPWM_MODE_OFF      3'h0
`define CPWM_MODE_EDGE     3'h6
`define CPWM_MODE_CENTER   3'h7
`define CPWM_TB_PCLK       3'h7
`define CPWM_TB_TMR1       3'h4
`define CPWM_SYNC_NONE     5'h00
`define CPWM_SYNC_SELF     5'h1F

`endif

/* verilog/cpwm_pkg.sv */
/*
 * Types of the compare PWM channel.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package cpwm_pkg;
    typedef enum logic {CPWM_RUN, CPWM_FAULT} cpwm_fstate_t;
endpackage : cpwm_pkg

/* verilog/cpwm_sync2.sv */
/*
 * Two-flop synchroniser for a group of asynchronous levels.
 * Assumes pclk and presetn of the channel.
 */
`timescale 1ns/1ns
`default_nettype none
module cpwm_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_q   <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : cpwm_sync2
`default_nettype wire

/* verilog/cpwm_tbsel.sv */
/*
 * Time-base selector: turns the select code into a one-cycle count enable.
 * Assumes timer prescaler ticks are one-cycle pulses on pclk.
 */
`timescale 1ns/1ns
`default_nettype none
`include "cpwm_consts.svh"
module cpwm_tbsel (
    input  wire logic [2:0] tb_sel,
    input  wire logic [4:0] tmr_tick,
    output logic            tick
);
    // Index 0 is timer one, index 4 timer five; codes 3..0 map timers five..two
    always_comb
    begin
        tick = 1'b0;
        case (tb_sel)
            `CPWM_TB_PCLK: tick = 1'b1;                       // [RULE11]
            `CPWM_TB_TMR1: tick = tmr_tick[0];                // [RULE9]
            3'h0, 3'h1, 3'h2, 3'h3: tick = tmr_tick[{1'b0, tb_sel[1:0]} + 3'h1]; // [RULE9]
            default: tick = 1'b0;                             // [RULE11]
        endcase
    end
endmodule : cpwm_tbsel
`default_nettype wire
